// File: fine_edge_placer.sv
`timescale 1ns/100ps
module fine_edge_placer (
    // Clock and reset.
    input  wire logic                                          aclk,
    input  wire logic                                          aresetn,
    // Timing from the divider.
    input  wire logic [2:0]                                    step,
    input  wire logic                                          periph_tick,
    // Mode for this timer and for the whole port.
    input  wire logic                                          timer_fine,
    input  wire logic                                          timer_plus,
    input  wire logic                                          port_fine,
    // Coarse waveform and compare low bits from the timer.
    input  wire logic [fine_res_pkg::OUTS_PER_TIMER-1:0]       wave_in,
    input  wire logic [fine_res_pkg::OUTS_PER_TIMER*3-1:0]     fine_bits,
    // Placed waveform.
    output logic [fine_res_pkg::OUTS_PER_TIMER-1:0]            wave_out
);

    localparam int N = fine_res_pkg::OUTS_PER_TIMER;

    // Sub-step at which a coarse edge is released. Normal mode moves in quad-rate ticks of two
    // sub-steps; plus mode uses every sub-step, standing in for both quad clock edges.
    function automatic logic [2:0] release_step(input logic [2:0] bits, input logic fine, input logic plus);
        logic [2:0] r;
        r = 3'h0;
        if (plus) begin
            r = bits;
        end else if (fine) begin
            r = {bits[1:0], 1'b0};
        end
        return r;
    endfunction : release_step

    logic [N-1:0] pend_reg;
    logic [N-1:0] wave_reg;
    logic [N-1:0] wave_next;
    logic [2:0]   dly_reg [N];

    assign wave_out = wave_reg;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pin
            wire logic [2:0] rel = release_step(fine_bits[g*3 +: 3], timer_fine, timer_plus);
            // Coarse edges are moved later by less than one peripheral cycle, so a pulse the timer
            // never produced cannot appear, though a pulse can come out as short as one aclk cycle.
            assign wave_next[g] = !port_fine ? wave_in[g] :
                                  (step == dly_reg[g]) ? pend_reg[g] : wave_reg[g];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pend_reg[g] <= 1'b0;
                    dly_reg[g]  <= 3'h0;
                    wave_reg[g] <= 1'b0;
                end else begin
                    if (periph_tick) begin
                        pend_reg[g] <= wave_in[g];
                        dly_reg[g]  <= rel;
                    end
                    wave_reg[g] <= wave_next[g];
                end
            end
        end
    endgenerate

endmodule : fine_edge_placer

// File: fine_res_pkg.sv
package fine_res_pkg;

    // Register bus geometry.
    localparam int              ADDR_W          = 4;
    localparam int              DATA_W          = 32;
    localparam logic [3:0]      CTRL_OFFSET     = 4'h0;
    localparam logic [1:0]      RESP_OKAY       = 2'h0;
    localparam logic [1:0]      RESP_SLVERR     = 2'h2;

    // Control register layout.
    localparam int              ENABLE_LSB      = 0;
    localparam int              PLUS_LSB        = 2;
    localparam logic [7:0]      CTRL_RESET      = 8'h00;
    localparam logic [7:0]      CTRL_WRITE_MASK = 8'h0F;

    // Timer and port geometry.
    localparam int              OUTS_PER_TIMER  = 4;
    localparam int              FINE_W          = 3;
    localparam int              COUNT_W         = 16;

    // Timing: aclk cycles per peripheral clock cycle, and per quad-rate tick.
    localparam int              SUB_STEPS       = 8;
    localparam int              QUAD_STEP       = 2;
    localparam logic [2:0]      LAST_STEP       = 3'(SUB_STEPS - 1);

    // Count masks applied while the fine path owns the low bits.
    localparam logic [15:0]     MASK_FINE       = 16'hFFFC;
    localparam logic [15:0]     MASK_PLUS       = 16'hFFF8;

    typedef struct packed {
        logic [1:0] fine_res_plus_select;
        logic [1:0] fine_res_enable;
    } control_t;

    typedef struct packed {
        logic [OUTS_PER_TIMER-1:0]        wave;
        logic [OUTS_PER_TIMER*FINE_W-1:0] fine_bits;
        logic [COUNT_W-1:0]               count;
    } timer_side_t;

endpackage : fine_res_pkg

// File: fine_res_props.sv
`timescale 1ns/100ps
module fine_res_props (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus.
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    input wire logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb,
    input wire logic [31:0] s_axi_wdata, s_axi_rdata,
    input wire logic [1:0] s_axi_bresp,
    // Timer sides and outputs.
    input fine_res_pkg::timer_side_t timer_four, timer_five,
    input wire logic [7:0] port_wave,
    input wire logic [15:0] count_read_four, count_read_five, event_count_four, event_count_five,
    input wire logic port_fine_active
);
    logic [3:0] sh, sh_q1, sh_q2, wa, ra, wd;
    logic       ws;
    wire        stab = (sh == sh_q1) && (sh == sh_q2);

    function automatic logic [15:0] msk(input logic f, input logic p);
        msk = p ? fine_res_pkg::MASK_PLUS : (f ? fine_res_pkg::MASK_FINE : 16'hFFFF);
    endfunction : msk

    // Shadow of the control field, committed when the write answer appears.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh <= 4'h0; sh_q1 <= 4'h0; sh_q2 <= 4'h0; wa <= 4'h0; ra <= 4'h0; wd <= 4'h0; ws <= 1'b0;
        end else begin
            sh_q1 <= sh;
            sh_q2 <= sh_q1;
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[3:0];
            if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
            if ($rose(s_axi_bvalid) && wa[3:2] == 2'h0 && ws) sh <= wd;
            if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_bresp_map: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == (wa[3:2] != 2'h0 ?
        fine_res_pkg::RESP_SLVERR : fine_res_pkg::RESP_OKAY)) else $error("write response code wrong");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
        else $error("reserved read bits not zero");
    a_rdata_ctrl: assert property ($rose(s_axi_rvalid) && ra[3:2] == 2'h0 |-> s_axi_rdata[3:0] == sh)
        else $error("control readback wrong");
    a_count_four: assert property (stab |-> count_read_four == ($past(timer_four.count) & msk(sh[0] | sh[2], sh[2])))
        else $error("timer four count read not masked");
    a_count_five: assert property (stab |-> count_read_five == ($past(timer_five.count) & msk(sh[1] | sh[3], sh[3])))
        else $error("timer five count read not masked");
    a_event_four: assert property (stab |-> event_count_four == ($past(timer_four.count) & msk(sh[0] | sh[2], sh[2])))
        else $error("timer four event count not masked");
    a_event_five: assert property (stab |-> event_count_five == ($past(timer_five.count) & msk(sh[1] | sh[3], sh[3])))
        else $error("timer five event count not masked");
    a_port_active: assert property (stab |-> port_fine_active == (sh != 4'h0))
        else $error("port fine flag wrong");
    a_pass_thru: assert property (stab && !port_fine_active && !$past(port_fine_active) |->
        port_wave == $past({timer_five.wave, timer_four.wave})) else $error("pass through wave wrong");
endmodule : fine_res_props

bind fine_resolution_extension fine_res_props fine_res_props_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_awaddr, .s_axi_araddr, .s_axi_wstrb,
    .s_axi_wdata, .s_axi_rdata, .s_axi_bresp, .timer_four, .timer_five, .port_wave, .count_read_four,
    .count_read_five, .event_count_four, .event_count_five, .port_fine_active
);

// File: fine_resolution_extension.sv
`timescale 1ns/100ps
module fine_resolution_extension (
    // Clock and reset.
    input  wire logic                                        aclk,
    input  wire logic                                        aresetn,
    // AXI4-Lite write address.
    input  wire logic                                        s_axi_awvalid,
    output logic                                             s_axi_awready,
    input  wire logic [fine_res_pkg::ADDR_W-1:0]             s_axi_awaddr,
    input  wire logic [2:0]                                  s_axi_awprot,
    // AXI4-Lite write data.
    input  wire logic                                        s_axi_wvalid,
    output logic                                             s_axi_wready,
    input  wire logic [31:0]                                 s_axi_wdata,
    input  wire logic [3:0]                                  s_axi_wstrb,
    // AXI4-Lite write response.
    output logic                                             s_axi_bvalid,
    input  wire logic                                        s_axi_bready,
    output logic [1:0]                                       s_axi_bresp,
    // AXI4-Lite read address.
    input  wire logic                                        s_axi_arvalid,
    output logic                                             s_axi_arready,
    input  wire logic [fine_res_pkg::ADDR_W-1:0]             s_axi_araddr,
    input  wire logic [2:0]                                  s_axi_arprot,
    // AXI4-Lite read data.
    output logic                                             s_axi_rvalid,
    input  wire logic                                        s_axi_rready,
    output logic [31:0]                                      s_axi_rdata,
    output logic [1:0]                                       s_axi_rresp,
    // Timer four and timer five sides.
    input  fine_res_pkg::timer_side_t                        timer_four,
    input  fine_res_pkg::timer_side_t                        timer_five,
    // Port pins and masked counts.
    output logic [2*fine_res_pkg::OUTS_PER_TIMER-1:0]        port_wave,
    output logic [fine_res_pkg::COUNT_W-1:0]                 count_read_four,
    output logic [fine_res_pkg::COUNT_W-1:0]                 count_read_five,
    output logic [fine_res_pkg::COUNT_W-1:0]                 event_count_four,
    output logic [fine_res_pkg::COUNT_W-1:0]                 event_count_five,
    output logic                                             port_fine_active
);

    localparam int N = fine_res_pkg::OUTS_PER_TIMER;

    function automatic logic word_hit(input logic [fine_res_pkg::ADDR_W-1:0] a);
        return a[fine_res_pkg::ADDR_W-1:2] == fine_res_pkg::CTRL_OFFSET[fine_res_pkg::ADDR_W-1:2];
    endfunction : word_hit

    function automatic logic [15:0] mask_count(input logic [15:0] c, input logic fine, input logic plus);
        logic [15:0] m;
        m = c;
        if (plus) begin
            m = c & fine_res_pkg::MASK_PLUS;
        end else if (fine) begin
            m = c & fine_res_pkg::MASK_FINE;
        end
        return m;
    endfunction : mask_count

    // Control register.
    fine_res_pkg::control_t ctrl_reg;
    fine_res_pkg::control_t ctrl_next;

    // Write channel state.
    logic                           aw_held_reg;
    logic                           w_held_reg;
    logic [fine_res_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [7:0]                     w_byte_reg;
    logic                           w_lane_reg;
    logic                           awready_reg;
    logic                           wready_reg;
    logic                           bvalid_reg;
    logic [1:0]                     bresp_reg;

    // Read channel state.
    logic                           arready_reg;
    logic                           rvalid_reg;
    logic [31:0]                    rdata_reg;
    logic [1:0]                     rresp_reg;

    wire logic aw_take  = s_axi_awvalid && awready_reg;
    wire logic w_take   = s_axi_wvalid && wready_reg;
    wire logic aw_have  = aw_held_reg || aw_take;
    wire logic w_have   = w_held_reg || w_take;
    wire logic [fine_res_pkg::ADDR_W-1:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    wire logic [7:0] wr_byte = w_held_reg ? w_byte_reg : s_axi_wdata[7:0];
    wire logic wr_lane  = w_held_reg ? w_lane_reg : s_axi_wstrb[0];
    wire logic wr_fire  = aw_have && w_have && !bvalid_reg;
    wire logic wr_hit   = word_hit(wr_addr);
    wire logic ar_take  = s_axi_arvalid && arready_reg;
    wire logic rd_hit   = word_hit(s_axi_araddr);

    // Bits above the two fields are never stored, so they read back as zero whatever is written.
    assign ctrl_next = (wr_fire && wr_hit && wr_lane) ?
                       fine_res_pkg::control_t'(wr_byte[3:0] & fine_res_pkg::CTRL_WRITE_MASK[3:0]) : ctrl_reg;

    wire logic [7:0] ctrl_byte = {4'h0, ctrl_reg};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg    <= fine_res_pkg::control_t'(fine_res_pkg::CTRL_RESET[3:0]);
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_byte_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= fine_res_pkg::RESP_OKAY;
        end else begin
            ctrl_reg <= ctrl_next;
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            aw_held_reg <= aw_have && !wr_fire;
            w_held_reg  <= w_have && !wr_fire;
            awready_reg <= !(aw_have && !wr_fire) && !(bvalid_reg && !s_axi_bready) && !wr_fire;
            wready_reg  <= !(w_have && !wr_fire) && !(bvalid_reg && !s_axi_bready) && !wr_fire;
            if (wr_fire) begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_hit ? fine_res_pkg::RESP_OKAY : fine_res_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h00000000;
            rresp_reg   <= fine_res_pkg::RESP_OKAY;
        end else begin
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_hit ? {24'h000000, ctrl_byte} : 32'h00000000;
                rresp_reg  <= rd_hit ? fine_res_pkg::RESP_OKAY : fine_res_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
            arready_reg <= !ar_take && !(rvalid_reg && !s_axi_rready);
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Mode decode. Plus mode implies the fine path for its timer.
    wire logic plus_on_timer_four = ctrl_reg.fine_res_plus_select[0];
    wire logic plus_on_timer_five = ctrl_reg.fine_res_plus_select[1];
    wire logic fine_on_timer_four = ctrl_reg.fine_res_enable[0] || plus_on_timer_four;
    wire logic fine_on_timer_five = ctrl_reg.fine_res_enable[1] || plus_on_timer_five;
    // The whole port follows either timer, which is why software must enable both sharing it.
    wire logic port_fine = fine_on_timer_four || fine_on_timer_five;

    logic [2:0] step;
    logic       periph_tick;

    // The aclk is the fine clock; the peripheral rate is one pulse every eight cycles.
    step_divider u_step_divider (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .step        (step),
        .periph_tick (periph_tick)
    );

    logic [N-1:0] wave_four;
    logic [N-1:0] wave_five;

    // Each timer keeps its coarse waveform generation whatever mode it runs in.
    fine_edge_placer u_place_four (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .step        (step),
        .periph_tick (periph_tick),
        .timer_fine  (fine_on_timer_four),
        .timer_plus  (plus_on_timer_four),
        .port_fine   (port_fine),
        .wave_in     (timer_four.wave),
        .fine_bits   (timer_four.fine_bits),
        .wave_out    (wave_four)
    );

    fine_edge_placer u_place_five (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .step        (step),
        .periph_tick (periph_tick),
        .timer_fine  (fine_on_timer_five),
        .timer_plus  (plus_on_timer_five),
        .port_fine   (port_fine),
        .wave_in     (timer_five.wave),
        .fine_bits   (timer_five.fine_bits),
        .wave_out    (wave_five)
    );

    assign port_wave = {wave_five, wave_four};

    logic [15:0] cnt_four_reg;
    logic [15:0] cnt_five_reg;
    logic [15:0] evt_four_reg;
    logic [15:0] evt_five_reg;
    logic        port_fine_reg;

    wire logic [15:0] cnt_four_next = mask_count(timer_four.count, fine_on_timer_four, plus_on_timer_four);
    wire logic [15:0] cnt_five_next = mask_count(timer_five.count, fine_on_timer_five, plus_on_timer_five);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_four_reg  <= 16'h0000;
            cnt_five_reg  <= 16'h0000;
            evt_four_reg  <= 16'h0000;
            evt_five_reg  <= 16'h0000;
            port_fine_reg <= 1'b0;
        end else begin
            cnt_four_reg  <= cnt_four_next;
            cnt_five_reg  <= cnt_five_next;
            evt_four_reg  <= cnt_four_next;
            evt_five_reg  <= cnt_five_next;
            port_fine_reg <= port_fine;
        end
    end

    assign count_read_four  = cnt_four_reg;
    assign count_read_five  = cnt_five_reg;
    assign event_count_four = evt_four_reg;
    assign event_count_five = evt_five_reg;
    assign port_fine_active = port_fine_reg;

endmodule : fine_resolution_extension

// File: fine_resolution_extension_tb.sv
`timescale 1ns/100ps
module fine_resolution_extension_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, port_fine_active, cmp_en;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb, cfg;
    logic [31:0] s_axi_wdata, s_axi_rdata, st;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] port_wave, ew, smp, wv;
    logic [15:0] count_read_four, count_read_five, event_count_four, event_count_five, ec4, ec5;
    logic [2:0] ph, fb, d, dl [8];
    fine_res_pkg::timer_side_t timer_four, timer_five;
    int n_mismatch, cmp_count;

    fine_resolution_extension fine_resolution_extension_i (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .timer_four, .timer_five, .port_wave, .count_read_four, .count_read_five,
        .event_count_four, .event_count_five, .port_fine_active);
    timer_model timer_model_i4 (.aclk, .aresetn, .rnd(st), .side(timer_four));
    timer_model timer_model_i5 (.aclk, .aresetn, .rnd({st[15:0], st[31:16]}), .side(timer_five));

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        xs = y ^ (y << 5);
    endfunction : xs

    function automatic logic [15:0] mk(input logic f, input logic p);
        mk = p ? fine_res_pkg::MASK_PLUS : (f ? fine_res_pkg::MASK_FINE : 16'hFFFF);
    endfunction : mk

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1; s_axi_wdata <= v; s_axi_wstrb <= s;
        s_axi_bready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            k++;
        end while (s_axi_bvalid !== 1'b1 && k < 50);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        if (k >= 50) begin
            n_mismatch++;
            summarize();
        end
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] ev, input logic [1:0] er);
        int k;
        @(posedge aclk);
        s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
        k = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            k++;
        end while (s_axi_rvalid !== 1'b1 && k < 50);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ev);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        if (k >= 50) begin
            n_mismatch++;
            summarize();
        end
    endtask : rd

    // Reference: sample coarse level at the tick, release it at the sub-step given by the fine bits.
    always @(posedge aclk) begin
        st <= aresetn ? xs(st) : 32'h0000_0040;
        if (!aresetn) begin
            ph = 3'h0; smp = 8'h00; ew = 8'h00; ec4 = 16'h0000; ec5 = 16'h0000; dl = '{default: 3'h0};
        end else begin
            wv = {timer_five.wave, timer_four.wave};
            for (int g = 0; g < 8; g++) begin
                fb = g < 4 ? timer_four.fine_bits[3*(g%4) +: 3] : timer_five.fine_bits[3*(g%4) +: 3];
                d = cfg[2+g/4] ? fb : (cfg[g/4] ? {fb[1:0], 1'b0} : 3'h0);
                if (cfg == 4'h0) ew[g] = wv[g];
                else if (ph == dl[g]) ew[g] = smp[g];
                // The release step is latched with the level at the tick, as the timer pairs them.
                if (ph == 3'h7) dl[g] = d;
            end
            if (ph == 3'h7) smp = wv;
            ph = ph + 3'h1;
            ec4 = timer_four.count & mk(cfg[0] | cfg[2], cfg[2]);
            ec5 = timer_five.count & mk(cfg[1] | cfg[3], cfg[3]);
        end
    end

    always @(negedge aclk) begin
        if (cmp_en) begin
            chk("port_wave", {24'h0, port_wave}, {24'h0, ew});
            chk("count_read_four", {16'h0, count_read_four}, {16'h0, ec4});
            chk("count_read_five", {16'h0, count_read_five}, {16'h0, ec5});
            chk("event_count_four", {16'h0, event_count_four}, {16'h0, ec4});
            chk("event_count_five", {16'h0, event_count_five}, {16'h0, ec5});
            chk("port_fine_active", {31'h0, port_fine_active}, {31'h0, cfg != 4'h0});
        end
    end

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    initial begin
        n_mismatch = 0; cmp_count = 0; cfg = 4'h0; cmp_en = 1'b0; aresetn = 1'b0;
        s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h0, 32'h0, fine_res_pkg::RESP_OKAY);
        $display("reset value done");
        wr(4'h4, 32'h0000_000F, 4'hF, fine_res_pkg::RESP_SLVERR);
        rd(4'hC, 32'h0, fine_res_pkg::RESP_SLVERR);
        wr(4'h0, 32'h0000_000F, 4'h0, fine_res_pkg::RESP_OKAY);
        rd(4'h0, 32'h0, fine_res_pkg::RESP_OKAY);
        $display("unmapped and strobe done");
        for (int c = 0; c < 16; c++) begin
            wr(4'h0, {st[31:4], 4'(c)}, 4'hF, fine_res_pkg::RESP_OKAY);
            cfg <= 4'(c);
            rd(4'h0, {28'h0, 4'(c)}, fine_res_pkg::RESP_OKAY);
            repeat (24) @(posedge aclk);
            cmp_en <= 1'b1;
            repeat (64) @(posedge aclk);
            cmp_en <= 1'b0;
            $display("config %h done", c);
        end
        summarize();
    end
endmodule : fine_resolution_extension_tb

// File: step_divider.sv
`timescale 1ns/100ps
module step_divider (
    // Clock and reset.
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Sub-step position inside one peripheral cycle.
    output logic [2:0]      step,
    output logic            periph_tick
);

    logic [2:0] step_reg;
    logic [2:0] step_next;

    assign step_next   = (step_reg == fine_res_pkg::LAST_STEP) ? 3'h0 : step_reg + 3'h1;
    assign step        = step_reg;
    assign periph_tick = (step_reg == fine_res_pkg::LAST_STEP);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_reg <= 3'h0;
        end else begin
            step_reg <= step_next;
        end
    end

endmodule : step_divider

// File: timer_model.sv
`timescale 1ns/100ps
module timer_model (
    // Clock and reset.
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    // Random source.
    input  wire logic [31:0]          rnd,
    // Side toward the extension.
    output fine_res_pkg::timer_side_t side
);
    logic [2:0] ph;

    // Low count bits stay noisy on purpose, so masking is really exercised.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ph <= 3'h0;
            side <= '0;
        end else begin
            ph <= ph + 3'h1;
            if (ph == 3'h7) begin
                side.wave <= rnd[3:0];
                side.fine_bits <= rnd[15:4];
                side.count <= {side.count[15:3] + 13'h1, rnd[18:16]};
            end
        end
    end
endmodule : timer_model
